// ==== rtc_pulse_and_irq_summary_tb_top.sv ====
// Testbench for the RTC pulse, square wave and interrupt summary block.
// Assumes rtcp_pkg and the host model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module rtc_pulse_and_irq_summary_tb_top;
  import rtcp_pkg::*;
  localparam int TG = 4;
  logic ref_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic tick = 1'b0;
  logic [3:0] roll = 4'h0;
  logic stopped = 1'b0;
  logic [3:0] trim = 4'h8;
  logic [15:0] grp = 16'h0000;
  logic pulse, sqw, irqp, wr, rd;
  logic [7:0] addr;
  logic [15:0] wdata;
  rtcp_word_t rdata, q;
  int fails = 0;
  int cmp_count = 0;
  int cycles = 0;

  always #50 ref_clk_i = ~ref_clk_i;

  rtcp_top u_dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .tb32k_tick_i(tick), .min_rollover_i(roll[0]), .hour_rollover_i(roll[1]),
    .day_rollover_i(roll[2]), .month_rollover_i(roll[3]),
    .seconds_counter_stopped_i(stopped), .trim_ticks_i(trim), .group_event_i(grp),
    .periodic_pulse_o(pulse), .square_wave_o(sqw), .irq_pending_o(irqp));

  rtcp_host_model u_host (.clk_i(ref_clk_i), .rdata_i(rdata), .addr_o(addr),
    .wdata_o(wdata), .wr_o(wr), .rd_o(rd));

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  // ****************************************
  // Timeout
  // ****************************************
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 50000) begin
      fails++;
      print_verdict();
    end
  end

  task automatic chk(input rtcp_word_t got, input rtcp_word_t exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic ev(input logic [15:0] v);
    @(posedge ref_clk_i);
    #10;
    grp = v;
  endtask : ev

  // Runs n ticks, rollover r on the first; counts square-wave rises and pulse-high cycles
  task automatic run_ticks(input int n, input logic [3:0] r, output int rise, output int hi);
    logic last;
    rise = 0;
    hi = 0;
    last = sqw;
    for (int i = 0; i < n * TG; i++) begin
      @(posedge ref_clk_i);
      #10;
      tick = (i % TG == 0);
      roll = (i == 0) ? r : 4'h0;
      if (sqw === 1'b1 && last === 1'b0) rise++;
      last = sqw;
      if (pulse === 1'b1) hi++;
    end
  endtask : run_ticks

  task automatic t_reset();
    chk({13'h0, pulse, sqw, irqp}, 16'h0000);
    reset_n_i = 1'b1;
    repeat (4) @(posedge ref_clk_i);
    u_host.access(1'b0, 8'h17, 16'h0, q);
    chk(q, 16'h0020);
    u_host.access(1'b1, 8'h18, 16'hFFFF, q);
    u_host.access(1'b0, 8'h18, 16'h0, q);
    chk(q, 16'h0000);
    u_host.access(1'b0, 8'h30, 16'h0, q);
    chk(q, 16'h0000);
    $display("test reset done");
  endtask : t_reset

  task automatic t_pulse();
    int rise, hi;
    for (int c = 0; c < 8; c++) begin
      u_host.access(1'b1, 8'h17, 16'hFF80 | 16'(c << 4), q);
      u_host.access(1'b0, 8'h17, 16'h0, q);
      chk(q, 16'(c << 4));
      for (int j = 0; j < 4; j++) begin
        run_ticks(3, 4'(1 << j), rise, hi);
        chk(16'(hi), (c == j + 2) ? 16'(TG) : 16'h0);
      end
    end
    stopped = 1'b1;
    u_host.access(1'b1, 8'h17, 16'h0020, q);
    u_host.access(1'b0, 8'h17, 16'h0, q);
    chk(q, 16'h0420);
    run_ticks(3, 4'h1, rise, hi);
    chk(16'(hi), 16'h0);
    stopped = 1'b0;
    $display("test pulse done");
  endtask : t_pulse

  task automatic t_square();
    int rise, hi;
    int codes[6] = '{0, 1, 12, 13, 14, 15};
    foreach (codes[k]) begin
      u_host.access(1'b1, 8'h17, 16'(codes[k]), q);
      run_ticks(2, 4'h0, rise, hi);
      run_ticks(64, 4'h0, rise, hi);
      chk(16'(rise), codes[k] == 0 ? 16'h0 : 16'(64 >> (16 - codes[k])));
    end
    $display("test square done");
  endtask : t_square

  task automatic t_summary();
    for (int b = 0; b < 16; b++) begin
      ev(16'(1 << b));
      ev(16'h0000);
      ev(16'h0000);
      chk({15'h0, irqp}, {15'h0, |(16'h33FF & 16'(1 << b))});
      u_host.access(1'b0, 8'h18, 16'h0, q);
      chk(q, 16'h33FF & 16'(1 << b));
      u_host.access(1'b0, 8'h18, 16'h0, q);
      chk(q, 16'h0000);
      chk({15'h0, irqp}, 16'h0000);
    end
    // event only on the clearing read's edge must survive it
    fork
      u_host.access(1'b0, 8'h18, 16'h0, q);
      begin
        ev(16'h0010);
        ev(16'h0000);
      end
    join
    chk(q, 16'h0000);
    chk({15'h0, irqp}, 16'h0001);
    u_host.access(1'b0, 8'h18, 16'h0, q);
    chk(q, 16'h0010);
    u_host.access(1'b0, 8'h18, 16'h0, q);
    chk(q, 16'h0000);
    $display("test summary done");
  endtask : t_summary

  // Ticks every cycle through one seconds wrap at 16384 Hz with an over-range trim;
  // the low run at the wrap is one tick plus at most eight, and the seconds pulse fires once
  task automatic t_trim();
    int lo, lo_max, hi;
    trim = 4'hF;
    u_host.access(1'b1, 8'h17, 16'h001F, q);
    lo = 0;
    lo_max = 0;
    hi = 0;
    for (int i = 0; i < 32800; i++) begin
      @(posedge ref_clk_i);
      #10;
      tick = 1'b1;
      if (sqw === 1'b0) lo++;
      else lo = 0;
      if (lo > lo_max) lo_max = lo;
      if (pulse === 1'b1) hi++;
    end
    tick = 1'b0;
    chk(16'(lo_max), 16'h0009);
    chk(16'(hi), 16'h0001);
    $display("test trim done");
  endtask : t_trim

  initial begin
    repeat (6) @(posedge ref_clk_i);
    #10;
    t_reset();
    t_pulse();
    t_square();
    t_summary();
    t_trim();
    print_verdict();
  end
endmodule : rtc_pulse_and_irq_summary_tb_top
`default_nettype wire

// ==== rtcp_host_model.sv ====
// Host model: single-cycle decoded register reads and writes.
// Assumes a free-running clock and that requests start after reset has settled.
`timescale 1ns/1ps
`default_nettype none

module rtcp_host_model (
  input wire logic clk_i,
  input wire rtcp_pkg::rtcp_word_t rdata_i,
  output logic [7:0] addr_o,
  output logic [15:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  import rtcp_pkg::*;

  initial begin
    addr_o = 8'h00;
    wdata_o = 16'h0000;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  task automatic access(input logic w, input logic [7:0] a, input logic [15:0] d,
                        output rtcp_word_t q);
    @(posedge clk_i);
    #10;
    addr_o = a;
    wdata_o = d;
    wr_o = w;
    rd_o = ~w;
    @(posedge clk_i);
    #10;
    wr_o = 1'b0;
    rd_o = 1'b0;
    // Released lines show the inverse so a stale value cannot pass
    addr_o = ~a;
    wdata_o = ~d;
    q = rdata_i;
  endtask : access
endmodule : rtcp_host_model
`default_nettype wire

// ==== rtcp_pkg.sv ====
// Types shared by the RTC pulse/summary block.
// Assumes rtcp_regs.svh is on the include path.
`include "rtcp_regs.svh"

package rtcp_pkg;

  typedef enum logic [2:0] {
    PINT_OFF = 3'h0,
    PINT_SEC = 3'h1,
    PINT_MIN = 3'h2,
    PINT_HOUR = 3'h3,
    PINT_DAY = 3'h4,
    PINT_MONTH = 3'h5
  } rtcp_pint_e;

  typedef enum logic [1:0] {
    PP_IDLE = 2'b01,
    PP_HIGH = 2'b10
  } rtcp_pp_state_e;

  typedef logic [15:0] rtcp_word_t;

endpackage : rtcp_pkg

// ==== rtcp_regs.svh ====
// Register offsets, field positions, reset values and limits for the RTC pulse/summary block.
// Assumes it is included by bare name from the package and the design modules.
`ifndef RTCP_REGS_SVH
`define RTCP_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define RTCP_OFS_TIME_CTRL 8'h17
`define RTCP_OFS_IRQ_SUMMARY 8'h18

// ****************************************
// Time control fields
// ****************************************
`define RTCP_STOPPED_BIT 10
`define RTCP_PINT_LSB 4
`define RTCP_PINT_MSB 6
`define RTCP_DSW_LSB 0
`define RTCP_DSW_MSB 3
`define RTCP_PINT_RESET 3'h2
`define RTCP_DSW_RESET 4'h0

// ****************************************
// Summary flag positions
// ****************************************
`define RTCP_OVERCURRENT_BIT 13
`define RTCP_UNDERVOLTAGE_BIT 12
`define RTCP_CURRENT_SINK_BIT 9
`define RTCP_EXTERNAL_BIT 8
`define RTCP_CODEC_BIT 7
`define RTCP_PIN_PORT_BIT 6
`define RTCP_AUX_CONV_BIT 5
`define RTCP_RTC_BIT 4
`define RTCP_SYSTEM_BIT 3
`define RTCP_CHARGER_BIT 2
`define RTCP_USB_BIT 1
`define RTCP_WAKEUP_BIT 0
`define RTCP_SUMMARY_MASK 16'h33FF
`define RTCP_SUMMARY_RESET 16'h0000

// ****************************************
// Timing
// ****************************************
`define RTCP_TRIM_MAX 4'h8
`define RTCP_DIV_LAST 15'h7FFF

`endif

// ==== rtcp_sqw_div.sv ====
// Square-wave divider of the 32 kHz timebase, with trim stretch at the seconds rollover.
// Assumes tick_i is a one-cycle pulse per 32.768 kHz period, synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "rtcp_regs.svh"

module rtcp_sqw_div (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic tick_i,
  input wire logic [3:0] sel_i,
  input wire logic [3:0] trim_i,
  output logic sqw_o,
  output logic sec_tick_o
);
  import rtcp_pkg::*;

  logic [14:0] cnt_reg;
  logic [3:0] hold_reg;
  logic sqw_reg;
  logic sec_tick_reg;
  logic [3:0] bit_idx;

  assign bit_idx = 4'hF - sel_i;

  // ****************************************
  // Divider with trim hold
  // ****************************************
  // trim hold bound
  // Holding the divider at zero only lengthens the low phase, never more than 8 ticks
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= 15'h0000;
      hold_reg <= 4'h0;
    end else if (tick_i) begin
      if (hold_reg != 4'h0) begin
        hold_reg <= hold_reg - 4'h1;
      end else begin
        cnt_reg <= cnt_reg + 15'h0001;
        if (cnt_reg == `RTCP_DIV_LAST) begin
          hold_reg <= (trim_i > `RTCP_TRIM_MAX) ? `RTCP_TRIM_MAX : trim_i;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sec_tick_reg <= 1'b0;
    end else begin
      sec_tick_reg <= tick_i && (hold_reg == 4'h0) && (cnt_reg == `RTCP_DIV_LAST);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sqw_reg <= 1'b0;
    end else begin
      sqw_reg <= (sel_i != 4'h0) && cnt_reg[bit_idx];
    end
  end

  assign sqw_o = sqw_reg;
  assign sec_tick_o = sec_tick_reg;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_trim_bound;
    hold_reg <= `RTCP_TRIM_MAX;
  endproperty
  a_trim_bound: assert property (p_trim_bound) else $error("trim hold above 8");

  property p_sqw_fastest;
    (sel_i == 4'hF) |=> (sqw_o == $past(cnt_reg[0]));
  endproperty
  a_sqw_fastest: assert property (p_sqw_fastest) else $error("16384 Hz tap wrong");

  property p_sqw_slowest;
    (sel_i == 4'h1) |=> (sqw_o == $past(cnt_reg[14]));
  endproperty
  a_sqw_slowest: assert property (p_sqw_slowest) else $error("1 Hz tap wrong");

endmodule : rtcp_sqw_div
`default_nettype wire

// ==== rtcp_top.sv ====
// RTC periodic pulse, divided square wave and first-level interrupt summary register.
// Assumes the serial control interface delivers decoded single-cycle register reads and
// writes, and that all timebase ticks arrive as one-cycle pulses on ref_clk_i.
//
// Overview of operation
// - Periodic pulse period from 3-bit select
// - Square wave 2^(n-1) Hz, code 0 off
// - Trim stretch at rollover at most 8 ticks
// - Summary flags at documented bit positions
// - Current-sink group flag at bit 9
// - Flags reset zero, read clears returned flags
// - Pulse one 32k period, suppressed when stopped
`timescale 1ns/1ps
`default_nettype none
`include "rtcp_regs.svh"

module rtcp_top (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output var rtcp_pkg::rtcp_word_t reg_rdata_o,
  input wire logic tb32k_tick_i,
  input wire logic min_rollover_i,
  input wire logic hour_rollover_i,
  input wire logic day_rollover_i,
  input wire logic month_rollover_i,
  input wire logic seconds_counter_stopped_i,
  input wire logic [3:0] trim_ticks_i,
  input wire logic [15:0] group_event_i,
  output logic periodic_pulse_o,
  output logic square_wave_o,
  output logic irq_pending_o
);
  import rtcp_pkg::*;

  logic rst_meta_reg;
  logic rst_n_reg;
  logic [2:0] periodic_pulse_select_reg;
  logic [3:0] square_wave_select_reg;
  rtcp_word_t flags_reg;
  rtcp_word_t flags_next;
  rtcp_word_t rdata_reg;
  rtcp_word_t set_vec;
  logic irq_pending_reg;
  rtcp_pp_state_e pp_state_reg;
  logic pulse_reg;
  logic sec_tick;
  logic period_event;
  logic sum_read;

  // ****************************************
  // Reset release
  // ****************************************
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // ****************************************
  // Control register
  // ****************************************
  always_ff @(posedge ref_clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      periodic_pulse_select_reg <= `RTCP_PINT_RESET;
      square_wave_select_reg <= `RTCP_DSW_RESET;
    end else if (reg_wr_i && reg_addr_i == `RTCP_OFS_TIME_CTRL) begin
      periodic_pulse_select_reg <= reg_wdata_i[`RTCP_PINT_MSB:`RTCP_PINT_LSB];
      square_wave_select_reg <= reg_wdata_i[`RTCP_DSW_MSB:`RTCP_DSW_LSB];
    end
  end

  // ****************************************
  // Square wave
  // ****************************************
  rtcp_sqw_div u_div (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n_reg),
    .tick_i(tb32k_tick_i),
    .sel_i(square_wave_select_reg),
    .trim_i(trim_ticks_i),
    .sqw_o(square_wave_o),
    .sec_tick_o(sec_tick)
  );

  // ****************************************
  // Periodic pulse
  // ****************************************
  // period select decode
  function automatic logic pint_hit(input logic [2:0] sel, input logic [4:0] ev);
    case (sel)
      PINT_SEC: pint_hit = ev[0];
      PINT_MIN: pint_hit = ev[1];
      PINT_HOUR: pint_hit = ev[2];
      PINT_DAY: pint_hit = ev[3];
      PINT_MONTH: pint_hit = ev[4];
      default: pint_hit = 1'b0;
    endcase
  endfunction : pint_hit

  assign period_event = pint_hit(periodic_pulse_select_reg,
    {month_rollover_i, day_rollover_i, hour_rollover_i, min_rollover_i, sec_tick});

  // one 32k period
  // Pulse drops on the next timebase tick; a stopped counter cuts it short at once
  always_ff @(posedge ref_clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      pp_state_reg <= PP_IDLE;
      pulse_reg <= 1'b0;
    end else begin
      case (pp_state_reg)
        PP_IDLE: begin
          if (period_event && !seconds_counter_stopped_i) begin
            pp_state_reg <= PP_HIGH;
            pulse_reg <= 1'b1;
          end
        end
        PP_HIGH: begin
          if (tb32k_tick_i || seconds_counter_stopped_i) begin
            pp_state_reg <= PP_IDLE;
            pulse_reg <= 1'b0;
          end
        end
        default: begin
          pp_state_reg <= PP_IDLE;
          pulse_reg <= 1'b0;
        end
      endcase
    end
  end

  assign periodic_pulse_o = pulse_reg;

  // ****************************************
  // Interrupt summary
  // ****************************************
  assign sum_read = reg_rd_i && (reg_addr_i == `RTCP_OFS_IRQ_SUMMARY);
  assign set_vec = group_event_i & `RTCP_SUMMARY_MASK;

  always_comb begin
    flags_next = flags_reg;
    if (sum_read) begin
      flags_next = 16'h0000;
    end
    flags_next = flags_next | set_vec;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      flags_reg <= `RTCP_SUMMARY_RESET;
      irq_pending_reg <= 1'b0;
    end else begin
      flags_reg <= flags_next;
      irq_pending_reg <= |flags_next;
    end
  end

  assign irq_pending_o = irq_pending_reg;

  // ****************************************
  // Read data
  // ****************************************
  always_ff @(posedge ref_clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      rdata_reg <= 16'h0000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `RTCP_OFS_TIME_CTRL: begin
          rdata_reg <= 16'h0000;
          rdata_reg[`RTCP_STOPPED_BIT] <= seconds_counter_stopped_i;
          rdata_reg[`RTCP_PINT_MSB:`RTCP_PINT_LSB] <= periodic_pulse_select_reg;
          rdata_reg[`RTCP_DSW_MSB:`RTCP_DSW_LSB] <= square_wave_select_reg;
        end
        `RTCP_OFS_IRQ_SUMMARY: begin
          rdata_reg <= flags_reg;
        end
        default: begin
          rdata_reg <= 16'h0000;
        end
      endcase
    end
  end

  assign reg_rdata_o = rdata_reg;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_reg);

  property p_pint_disabled;
    (pp_state_reg == PP_IDLE && (periodic_pulse_select_reg == 3'h0 ||
      periodic_pulse_select_reg[2:1] == 2'h3)) |=> !periodic_pulse_o;
  endproperty
  a_pint_disabled: assert property (p_pint_disabled) else $error("pulse while disabled");

  property p_pint_min;
    (pp_state_reg == PP_IDLE && periodic_pulse_select_reg == 3'h2 && min_rollover_i &&
      !seconds_counter_stopped_i) |=> periodic_pulse_o;
  endproperty
  a_pint_min: assert property (p_pint_min) else $error("minute pulse missing");

  property p_sqw_off;
    (square_wave_select_reg == 4'h0) |=> !square_wave_o;
  endproperty
  a_sqw_off: assert property (p_sqw_off) else $error("square wave while off");

  property p_pulse_end;
    (periodic_pulse_o && tb32k_tick_i) |=> !periodic_pulse_o;
  endproperty
  a_pulse_end: assert property (p_pulse_end) else $error("pulse over one period");

  property p_stop_suppress;
    seconds_counter_stopped_i |=> !periodic_pulse_o;
  endproperty
  a_stop_suppress: assert property (p_stop_suppress) else $error("pulse while stopped");

  property p_reserved_zero;
    (flags_reg[11:10] == 2'h0) && (flags_reg[15:14] == 2'h0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved flag set");

  property p_overcurrent_pos;
    group_event_i[13] |=> flags_reg[`RTCP_OVERCURRENT_BIT];
  endproperty
  a_overcurrent_pos: assert property (p_overcurrent_pos) else $error("bit 13 lost");

  property p_sink_pos;
    group_event_i[9] |=> flags_reg[`RTCP_CURRENT_SINK_BIT];
  endproperty
  a_sink_pos: assert property (p_sink_pos) else $error("current sink flag missing");

  property p_read_returns;
    sum_read |=> (reg_rdata_o == $past(flags_reg));
  endproperty
  a_read_returns: assert property (p_read_returns) else $error("summary read wrong");

  property p_read_clears;
    (sum_read && set_vec == 16'h0000) |=> (flags_reg == 16'h0000);
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("read did not clear");

  property p_set_wins;
    sum_read |=> ((flags_reg & $past(set_vec)) == $past(set_vec));
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost on read");

  c_pulse: cover property ($rose(periodic_pulse_o));
  c_clear: cover property (sum_read && flags_reg != 16'h0000);
  c_collide: cover property (sum_read && set_vec != 16'h0000);
  c_sqw: cover property ($rose(square_wave_o));

endmodule : rtcp_top
`default_nettype wire
